// [logic/lrw_regs.vh]
// Purpose: Register offsets, field positions and reset values of the
//          receive address window decoder.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word.
// Notes:   Definitions only; included by bare name.
`ifndef LRW_REGS_VH
`define LRW_REGS_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define LRW_WIN0_CTRL      8'h60
`define LRW_WIN0_BASE_MASK 8'h64
`define LRW_WIN1_CTRL      8'h68
`define LRW_WIN1_BASE_MASK 8'h6c
`define LRW_WIN2_CTRL      8'h70
`define LRW_WIN2_BASE_MASK 8'h74
`define LRW_STATUS         8'h78
`define LRW_WIN_STRIDE     8
`define LRW_WIN_COUNT      3

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define LRW_CTRL_ON_BIT    31
`define LRW_CTRL_XLATE_BIT 30
`define LRW_CTRL_TGT_HI    29
`define LRW_CTRL_TGT_LO    0
`define LRW_CTRL_OLD_MASK  32'hc07fffff
`define LRW_CTRL_RESET     32'h00000000

// ---------------------------------------------------------------------------
// Base and mask register fields
// ---------------------------------------------------------------------------
`define LRW_BASE_HI        31
`define LRW_BASE_LO        16
`define LRW_MASK_HI        15
`define LRW_MASK_LO        0
`define LRW_BM_RESET       32'h00000000

// ---------------------------------------------------------------------------
// Address layout
// ---------------------------------------------------------------------------
`define LRW_WIN_ADDR_LO    24
`define LRW_RX_ADDR_W      40
`define LRW_OUT_ADDR_W     54
`define LRW_STATUS_RESET   32'h00000000

`endif

// [logic/lrw_rx_window_decode.v]
// Purpose: Decodes addresses received from the host link against three
//          programmable windows, translating hits towards the processor and
//          returning misses to the link as peer forwards.
// Assumes: All inputs come from logic on clk_sys_in; Avalon-MM slave with
//          waitrequest; one request held in flight at a time.
// Notes:   Configuration is sampled when a request is taken.
//          Waitrequest and read data come straight from flops.
//
// Register access over Avalon-MM was chosen for this implementation.
`include "lrw_regs.vh"

module lrw_rx_window_decode
#(
  parameter CMD_W   = 64,
  parameter OLD_REV = 0
)
(
  input  wire                        clk_sys_in,
  input  wire                        rst_n_in,
  // Avalon-MM slave
  input  wire [7:0]                  avs_address_in,
  input  wire                        avs_read_in,
  input  wire                        avs_write_in,
  input  wire [31:0]                 avs_writedata_in,
  input  wire [3:0]                  avs_byteenable_in,
  output wire [31:0]                 avs_readdata_out,
  output wire                        avs_waitrequest_out,
  // Requests received from the link
  input  wire                        rx_valid_in,
  input  wire [`LRW_RX_ADDR_W-1:0]   rx_addr_in,
  input  wire [CMD_W-1:0]            rx_cmd_in,
  output wire                        rx_ready_out,
  // Towards the processor
  output wire                        cpu_valid_out,
  output wire [`LRW_OUT_ADDR_W-1:0]  cpu_addr_out,
  output wire [CMD_W-1:0]            cpu_cmd_out,
  output wire [1:0]                  cpu_win_out,
  input  wire                        cpu_ready_in,
  // Back onto the link
  output wire                        peer_forward_valid_out,
  output wire [`LRW_RX_ADDR_W-1:0]   peer_forward_addr_out,
  output wire [CMD_W-1:0]            peer_forward_cmd_out,
  input  wire                        peer_forward_ready_in
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  localparam NW   = `LRW_WIN_COUNT;
  localparam MW   = `LRW_BASE_HI - `LRW_BASE_LO + 1;
  localparam TW   = `LRW_CTRL_TGT_HI - `LRW_CTRL_TGT_LO + 1;
  localparam LO_W = `LRW_WIN_ADDR_LO;

  // Register values as seen by the read multiplexer
  wire [31:0]                 ctrl_rd  [0:NW-1];
  wire [31:0]                 bm_rd    [0:NW-1];
  wire [NW-1:0]               hit;
  wire [`LRW_OUT_ADDR_W-1:0]  xlate_addr [0:NW-1];

  reg                         ack_reg;
  reg                         ack_next;
  reg                         wait_reg;
  reg                         wait_next;
  reg  [31:0]                 rdata_reg;
  reg  [31:0]                 rdata_next;
  wire [31:0]                 be_mask;
  wire                        wr_go;

  reg  [15:0]                 cpu_cnt_reg;
  reg  [15:0]                 peer_cnt_reg;
  reg  [1:0]                  last_win_reg;
  reg                         last_hit_reg;

  reg                         rx_ready_reg;
  reg                         cpu_valid_reg;
  reg                         peer_valid_reg;
  reg  [`LRW_OUT_ADDR_W-1:0]  addr_reg;
  reg  [CMD_W-1:0]            cmd_reg;
  reg  [1:0]                  win_reg;

  reg                         any_hit;
  reg  [1:0]                  sel_win;
  reg  [`LRW_OUT_ADDR_W-1:0]  sel_addr;
  integer                     k;

  wire                        take;
  wire                        drain;
  wire                        full;
  wire                        full_next;

  // -------------------------------------------------------------------------
  // Bus handshake
  // -------------------------------------------------------------------------
  // Each access is answered with waitrequest low one cycle after it appears;
  // a write takes effect on the edge where waitrequest is seen low.
  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wr_go   = ack_reg & avs_write_in;

  always @*
  begin
    ack_next  = (avs_read_in | avs_write_in) & ~ack_reg;
    wait_next = ~ack_next;
  end

  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ack_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg  <= ack_next;
      wait_reg <= wait_next;
      if (ack_next & avs_read_in)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // A separate flop keeps waitrequest free of output logic; it is
  // high in reset so nothing is accepted before the registers are ready
  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out    = rdata_reg;

  // -------------------------------------------------------------------------
  // Window registers and match logic
  // -------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NW; i = i + 1)
    begin : g_win
      localparam integer CO = `LRW_WIN0_CTRL + i * `LRW_WIN_STRIDE;
      localparam integer BO = `LRW_WIN0_BASE_MASK + i * `LRW_WIN_STRIDE;
      // Each window keeps its own pair of registers
      reg  [31:0]   ctrl_reg;
      reg  [31:0]   bm_reg;
      wire [MW-1:0] base;
      wire [MW-1:0] mask;
      wire [31:0]   ctrl_wr;

      // Older parts hold the top translation bits at zero
      assign ctrl_wr = (OLD_REV != 0) ? (avs_writedata_in & `LRW_CTRL_OLD_MASK)
                                      : avs_writedata_in;

      // Byte lanes with their enable low keep their old contents
      always @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
        begin
          ctrl_reg <= `LRW_CTRL_RESET;
          bm_reg   <= `LRW_BM_RESET;
        end
        else if (wr_go && avs_address_in == CO[7:0])
        begin
          ctrl_reg <= (ctrl_reg & ~be_mask) | (ctrl_wr & be_mask);
        end
        else if (wr_go && avs_address_in == BO[7:0])
        begin
          bm_reg <= (bm_reg & ~be_mask) | (avs_writedata_in & be_mask);
        end
      end

      assign ctrl_rd[i] = ctrl_reg;
      assign bm_rd[i]   = bm_reg;
      assign base = bm_reg[`LRW_BASE_HI:`LRW_BASE_LO];
      assign mask = bm_reg[`LRW_MASK_HI:`LRW_MASK_LO];

      // Mask shape is left to software; any pattern is compared bitwise
      assign hit[i] = ctrl_reg[`LRW_CTRL_ON_BIT] &
                      ((base & mask) ==
                       (rx_addr_in[`LRW_RX_ADDR_W-1:LO_W] & mask));

      assign xlate_addr[i] = ctrl_reg[`LRW_CTRL_XLATE_BIT]
        ? ({ctrl_reg[`LRW_CTRL_TGT_HI:`LRW_CTRL_TGT_LO], {LO_W{1'b0}}} |
           {{(TW + LO_W - `LRW_RX_ADDR_W){1'b0}},
            rx_addr_in[`LRW_RX_ADDR_W-1:LO_W] & ~mask,
            rx_addr_in[LO_W-1:0]})
        : {{(`LRW_OUT_ADDR_W - `LRW_RX_ADDR_W){1'b0}}, rx_addr_in};
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Window priority
  // -------------------------------------------------------------------------
  // Walk from the top down so the lowest matching window wins
  // Misses leave window index zero and the address untouched
  always @*
  begin
    any_hit  = 1'b0;
    sel_win  = 2'b00;
    sel_addr = {{(`LRW_OUT_ADDR_W - `LRW_RX_ADDR_W){1'b0}}, rx_addr_in};
    for (k = NW - 1; k >= 0; k = k - 1)
    begin
      if (hit[k])
      begin
        any_hit  = 1'b1;
        sel_win  = k[1:0];
        sel_addr = xlate_addr[k];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Read multiplexer
  // -------------------------------------------------------------------------
  // Unmapped offsets read as zero and ignore writes
  always @*
  begin
    if (avs_address_in == `LRW_WIN0_CTRL)
    begin
      rdata_next = ctrl_rd[0];
    end
    else if (avs_address_in == `LRW_WIN0_BASE_MASK)
    begin
      rdata_next = bm_rd[0];
    end
    else if (avs_address_in == `LRW_WIN1_CTRL)
    begin
      rdata_next = ctrl_rd[1];
    end
    else if (avs_address_in == `LRW_WIN1_BASE_MASK)
    begin
      rdata_next = bm_rd[1];
    end
    else if (avs_address_in == `LRW_WIN2_CTRL)
    begin
      rdata_next = ctrl_rd[2];
    end
    else if (avs_address_in == `LRW_WIN2_BASE_MASK)
    begin
      rdata_next = bm_rd[2];
    end
    else if (avs_address_in == `LRW_STATUS)
    begin
      rdata_next = {peer_cnt_reg[12:0], last_hit_reg, last_win_reg, cpu_cnt_reg};
    end
    else
    begin
      rdata_next = 32'h00000000;
    end
  end

  // -------------------------------------------------------------------------
  // Request stage
  // -------------------------------------------------------------------------
  // One request is held at a time; ready returns on the same edge that it leaves.
  assign full      = cpu_valid_reg | peer_valid_reg;
  assign drain     = (cpu_valid_reg & cpu_ready_in) | (peer_valid_reg & peer_forward_ready_in);
  assign take      = rx_valid_in & rx_ready_reg;
  assign full_next = (full & ~drain) | take;

  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rx_ready_reg   <= 1'b0;
      cpu_valid_reg  <= 1'b0;
      peer_valid_reg <= 1'b0;
      addr_reg       <= {`LRW_OUT_ADDR_W{1'b0}};
      cmd_reg        <= {CMD_W{1'b0}};
      win_reg        <= 2'b00;
    end
    else
    begin
      rx_ready_reg <= ~full_next;
      if (take)
      begin
        cpu_valid_reg  <= any_hit;
        peer_valid_reg <= ~any_hit;
        // Misses keep the received address, zero-extended
        addr_reg       <= any_hit ? sel_addr
                                  : {{(`LRW_OUT_ADDR_W - `LRW_RX_ADDR_W){1'b0}}, rx_addr_in};
        cmd_reg        <= rx_cmd_in;
        win_reg        <= sel_win;
      end
      else if (drain)
      begin
        cpu_valid_reg  <= 1'b0;
        peer_valid_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Status counters
  // -------------------------------------------------------------------------
  // Both counters wrap and count at the taking edge, so a request
  // shows in the status word before it leaves the block
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cpu_cnt_reg  <= 16'h0000;
      peer_cnt_reg <= 16'h0000;
      last_win_reg <= 2'b00;
      last_hit_reg <= 1'b0;
    end
    else if (take)
    begin
      last_hit_reg <= any_hit;
      last_win_reg <= sel_win;
      if (any_hit)
      begin
        cpu_cnt_reg <= cpu_cnt_reg + 16'h0001;
      end
      else
      begin
        peer_cnt_reg <= peer_cnt_reg + 16'h0001;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign rx_ready_out           = rx_ready_reg;
  assign cpu_valid_out          = cpu_valid_reg;
  assign cpu_addr_out           = addr_reg;
  assign cpu_cmd_out            = cmd_reg;
  assign cpu_win_out            = win_reg;
  assign peer_forward_valid_out = peer_valid_reg;
  // The link side only needs the low address bits of the held word
  assign peer_forward_addr_out  = addr_reg[`LRW_RX_ADDR_W-1:0];
  assign peer_forward_cmd_out   = cmd_reg;

endmodule // lrw_rx_window_decode

// [dv/lrw_chk_properties.sv]
// Purpose: Timing checks on the window decoder's bus and link ports.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Bound to every instance of the decoder.
module lrw_chk
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        rx_valid_in,
  input wire logic [39:0] rx_addr_in,
  input wire logic        rx_ready_out,
  input wire logic        cpu_valid_out,
  input wire logic [53:0] cpu_addr_out,
  input wire logic        cpu_ready_in,
  input wire logic        peer_forward_valid_out,
  input wire logic [39:0] peer_forward_addr_out,
  input wire logic        peer_forward_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cfg_wr_reg;
  // Set once any register write lands; windows stay shut before that
  always @(posedge clk_sys_in)
    cfg_wr_reg <= rst_n_in & (cfg_wr_reg | (avs_write_in & ~avs_waitrequest_out));
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low one cycle after request");
  property p_wait_pulse;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_cause;
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("waitrequest fell with no request");
  property p_unmapped;
    !avs_waitrequest_out && avs_read_in && (avs_address_in < 8'h60 || avs_address_in > 8'h78)
      |-> avs_readdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_no_hit_idle;
    !cfg_wr_reg |-> !cpu_valid_out;
  endproperty
  a_no_hit_idle: assert property (p_no_hit_idle) else $error("hit with windows at reset");
  property p_answer;
    rx_valid_in && rx_ready_out |=> (cpu_valid_out != peer_forward_valid_out) && !rx_ready_out;
  endproperty
  a_answer: assert property (p_answer) else $error("taken request not routed one way");
  property p_peer_addr;
    rx_valid_in && rx_ready_out ##1 peer_forward_valid_out |-> peer_forward_addr_out == $past(rx_addr_in);
  endproperty
  a_peer_addr: assert property (p_peer_addr) else $error("peer forward address altered");
  property p_cpu_stand;
    cpu_valid_out && !cpu_ready_in |=> cpu_valid_out && $stable(cpu_addr_out);
  endproperty
  a_cpu_stand: assert property (p_cpu_stand) else $error("processor request dropped or changed");
  property p_peer_stand;
    peer_forward_valid_out && !peer_forward_ready_in |=> peer_forward_valid_out && $stable(peer_forward_addr_out);
  endproperty
  a_peer_stand: assert property (p_peer_stand) else $error("peer forward dropped or changed");
  property p_release;
    cpu_valid_out && cpu_ready_in |=> !cpu_valid_out && rx_ready_out;
  endproperty
  a_release: assert property (p_release) else $error("accept did not free the link side");
endmodule // lrw_chk

bind lrw_rx_window_decode lrw_chk u_lrw_chk (.clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .rx_valid_in, .rx_addr_in, .rx_ready_out,
  .cpu_valid_out, .cpu_addr_out, .cpu_ready_in, .peer_forward_valid_out, .peer_forward_addr_out,
  .peer_forward_ready_in);

// [dv/lrw_link_partner.sv]
// Purpose: Processor and link consumers that accept at random.
// Assumes: Ready is a level sampled with valid.
// Notes:   Stalls exercise held outputs.
module lrw_link_partner
#(
  parameter STALL_PCT = 40
)
(
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  output logic      cpu_ready_out,
  output logic      peer_forward_ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge clk_sys_in)
  begin
    cpu_ready_out          <= rst_n_in && ($urandom % 100 >= STALL_PCT);
    peer_forward_ready_out <= rst_n_in && ($urandom % 100 >= STALL_PCT);
  end
endmodule // lrw_link_partner

// [dv/link_rx_address_window_decode_tb_top.sv]
// Purpose: Self-checking bench for the receive window decoder.
// Assumes: OLD_REV 0, plus an OLD_REV 1 copy checked on read data; 64-bit payload.
// Notes:   Bench model of windows is compared at every result.
module link_rx_address_window_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic        rx_valid_in, rx_ready_out, cpu_valid_out, cpu_ready_in;
  logic        peer_forward_valid_out, peer_forward_ready_in;
  logic [7:0]  avs_address_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q, q_old, avs_readdata_old;
  logic [2:0]  last_q;
  logic [39:0] rx_addr_in, peer_forward_addr_out;
  logic [63:0] rx_cmd_in, cpu_cmd_out, peer_forward_cmd_out;
  logic [53:0] cpu_addr_out;
  logic [1:0]  cpu_win_out;
  logic [31:0] r [0:5];
  logic [56:0] exp_q [$];
  logic [63:0] cmd_q [$];
  int          failures, comparisons, hits, misses;

  lrw_rx_window_decode #(.CMD_W(64), .OLD_REV(0)) u_lrw_rx_window_decode (.clk_sys_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .rx_valid_in, .rx_addr_in, .rx_cmd_in, .rx_ready_out,
    .cpu_valid_out, .cpu_addr_out, .cpu_cmd_out, .cpu_win_out, .cpu_ready_in, .peer_forward_valid_out,
    .peer_forward_addr_out, .peer_forward_cmd_out, .peer_forward_ready_in);
  // Older revision on the same bus and link; only its read data is compared
  lrw_rx_window_decode #(.CMD_W(64), .OLD_REV(1)) u_lrw_rx_window_decode_old (.clk_sys_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out(avs_readdata_old), .avs_waitrequest_out(), .rx_valid_in, .rx_addr_in, .rx_cmd_in,
    .rx_ready_out(), .cpu_valid_out(), .cpu_addr_out(), .cpu_cmd_out(), .cpu_win_out(), .cpu_ready_in,
    .peer_forward_valid_out(), .peer_forward_addr_out(), .peer_forward_cmd_out(), .peer_forward_ready_in);
  lrw_link_partner u_lrw_link_partner (.clk_sys_in, .rst_n_in, .cpu_ready_out(cpu_ready_in),
    .peer_forward_ready_out(peer_forward_ready_in));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic test_done();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys_in);
    avs_read_in       <= !wr;
    avs_write_in      <= wr;
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    q     = avs_readdata_out;
    q_old = avs_readdata_old;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    if (wr && a >= 8'h60 && a <= 8'h74)
      for (int b = 0; b < 4; b++) if (be[b]) r[(a - 8'h60) >> 2][8*b +: 8] = d[8*b +: 8];
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    bus(1'b0, a, 32'h0, 4'hf);
    e = (a >= 8'h60 && a <= 8'h74) ? r[(a - 8'h60) >> 2] : 32'h0;
    chk({32'h0, q}, {32'h0, e});
    chk({32'h0, q_old}, {32'h0, a[2] ? e : e & 32'hc07fffff});
  endtask

  // Lowest enabled matching window wins; {hit, window, address}
  function automatic logic [56:0] model(input logic [39:0] a);
    logic [15:0] m;
    for (int w = 0; w < 3; w++)
    begin
      m = r[2*w+1][15:0];
      if (r[2*w][31] && ((r[2*w+1][31:16] & m) == (a[39:24] & m)))
        return {1'b1, 2'(w), r[2*w][30] ? ({r[2*w][29:0], 24'h0} | {14'h0, a[39:24] & ~m, a[23:0]})
                                        : {14'h0, a}};
    end
    return {3'b000, 14'h0, a};
  endfunction

  always @(posedge clk_sys_in)
  begin
    if (rst_n_in && rx_valid_in && rx_ready_out)
    begin
      exp_q.push_back(model(rx_addr_in));
      cmd_q.push_back(rx_cmd_in);
      last_q <= model(rx_addr_in) >> 54;
    end
    if (rst_n_in && cpu_valid_out && cpu_ready_in)
    begin
      chk({7'h0, 1'b1, cpu_win_out, cpu_addr_out}, {7'h0, exp_q.pop_front()});
      chk(cpu_cmd_out, cmd_q.pop_front());
      hits++;
    end
    if (rst_n_in && peer_forward_valid_out && peer_forward_ready_in)
    begin
      chk({7'h0, 17'h0, peer_forward_addr_out}, {7'h0, exp_q.pop_front()});
      chk(peer_forward_cmd_out, cmd_q.pop_front());
      misses++;
    end
  end

  task automatic send(input int cnt);
    logic [39:0] ad;
    int          w;
    repeat (cnt)
    begin
      w = $urandom % 3;
      ad = {8'($urandom), 32'($urandom)};
      if ($urandom % 4 != 0)
        ad[39:24] = (r[2*w+1][31:16] & r[2*w+1][15:0]) | (ad[39:24] & ~r[2*w+1][15:0]);
      @(posedge clk_sys_in);
      rx_valid_in <= 1'b1;
      rx_addr_in  <= ad;
      rx_cmd_in   <= {$urandom, $urandom};
      do @(posedge clk_sys_in); while (rx_ready_out !== 1'b1);
      rx_valid_in <= 1'b0;
    end
  endtask

  task automatic traffic();
    for (int w = 0; w < 3; w++)
    begin
      bus(1'b1, 8'(8'h60 + 8*w), $urandom, 4'hf);
      bus(1'b1, 8'(8'h64 + 8*w), {16'($urandom), 16'hffff << ($urandom % 17)}, 4'hf);
    end
    send(16);
  endtask

  initial
  begin
    #300000;
    failures++;
    test_done();
  end

  initial
  begin
    {rst_n_in, avs_read_in, avs_write_in, rx_valid_in} = 4'h0;
    {avs_address_in, avs_byteenable_in, avs_writedata_in, rx_addr_in, rx_cmd_in} = '0;
    {failures, comparisons, hits, misses} = '0;
    foreach (r[i]) r[i] = 32'h0;
    void'($urandom(32'h9f4d));
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int a = 8'h60; a <= 8'h78; a += 4) rd(a[7:0]);
    $display("test reset values done");
    send(8);
    repeat (30) @(posedge clk_sys_in);
    chk(64'(hits), 64'h0);
    chk(64'(misses), 64'h8);
    $display("test windows off done");
    for (int a = 8'h60; a <= 8'h74; a += 4)
    begin
      bus(1'b1, a[7:0], $urandom, 4'hf);
      bus(1'b1, a[7:0], $urandom, 4'h5);
      rd(a[7:0]);
    end
    bus(1'b1, 8'h7c, $urandom, 4'hf);
    rd(8'h7c);
    rd(8'h00);
    $display("test register access done");
    repeat (12) traffic();
    repeat (30) @(posedge clk_sys_in);
    chk(64'(exp_q.size()), 64'h0);
    bus(1'b0, 8'h78, 32'h0, 4'hf);
    chk({32'h0, q}, {32'h0, 13'(misses), last_q, 16'(hits)});
    $display("test window traffic done");
    test_done();
  end
endmodule // link_rx_address_window_decode_tb_top
